// ### feap_pkg.sv
package feap_pkg;

	// ****************************************************************
	// array geometry
	// ****************************************************************
	localparam int FLASH_BYTES = 131072;
	localparam int ERASE_BYTES = 1024;
	localparam int PROT_BYTES = 2048;
	localparam int ADDR_W = 17;
	localparam int WORD_LSB = 2;
	localparam int ERASE_LSB = 10;
	localparam int PROT_LSB = 11;
	localparam int DATA_W = 32;
	localparam int WADDR_W = ADDR_W - WORD_LSB;
	localparam int ERASE_IDX_W = ADDR_W - ERASE_LSB;
	localparam int PROT_IDX_W = ADDR_W - PROT_LSB;
	localparam int WCNT_W = ERASE_LSB - WORD_LSB;
	localparam int N_ERASE = FLASH_BYTES / ERASE_BYTES;
	localparam int N_PROT = FLASH_BYTES / PROT_BYTES;

	// ****************************************************************
	// values
	// ****************************************************************
	localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffff_ffff;
	localparam logic [DATA_W-1:0] DENIED_WORD = 32'h0000_0000;
	localparam logic [WCNT_W-1:0] WCNT_LAST = 8'hff;

	// ****************************************************************
	// access kinds seen by the protection check
	// ****************************************************************
	typedef enum logic [2:0] {
		KIND_FETCH = 3'b001,
		KIND_DATA = 3'b010,
		KIND_MODIFY = 3'b100
	} feap_kind_t;

endpackage : feap_pkg

// ### feap_chk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface feap_chk_if;
	logic [feap_pkg::ADDR_W-1:0] addr;
	feap_pkg::feap_kind_t kind;
	logic allow;

	modport req (output addr, output kind, input allow);
	modport chk (input addr, input kind, output allow);
endinterface : feap_chk_if
`default_nettype wire

// ### feap_prot_chk.sv
`timescale 1ns/1ps
`default_nettype none
module feap_prot_chk (
	feap_chk_if.chk bus,
	input wire logic [feap_pkg::N_PROT-1:0] i_prot_rd_en,
	input wire logic [feap_pkg::N_PROT-1:0] i_prot_pe_en
);
	logic [feap_pkg::PROT_IDX_W-1:0] unit;

	// ****************************************************************
	// protection decode
	// ****************************************************************
	assign unit = bus.addr[feap_pkg::ADDR_W-1:feap_pkg::PROT_LSB];

	always_comb begin
		case (bus.kind)
			feap_pkg::KIND_FETCH: bus.allow = 1'b1;
			feap_pkg::KIND_DATA: bus.allow = i_prot_rd_en[unit];
			feap_pkg::KIND_MODIFY: bus.allow = i_prot_pe_en[unit];
			default: bus.allow = 1'b0;
		endcase
	end
endmodule : feap_prot_chk
`default_nettype wire

// ### feap_ctrl.sv
// Summary of operation
// - The 128 KB array is split into 1 KB erase units, each erased alone without touching others.
// - A finished erase leaves every bit of the 1 KB unit at one.
// - Protection is held per 2 KB pair of erase units, both units sharing one setting.
// - A read-only protection unit refuses every erase and program request.
// - An execute-only unit refuses erase and program and serves only instruction fetch reads.
// - Permitted reads complete in one system clock cycle with no wait states.
`timescale 1ns/1ps
`default_nettype none
module feap_ctrl (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [feap_pkg::N_PROT-1:0] i_prot_rd_en,
	input wire logic [feap_pkg::N_PROT-1:0] i_prot_pe_en,
	input wire logic i_if_req,
	input wire logic [feap_pkg::ADDR_W-1:0] i_if_addr,
	output logic o_if_valid,
	output logic [feap_pkg::DATA_W-1:0] o_if_rdata,
	input wire logic i_dr_req,
	input wire logic [feap_pkg::ADDR_W-1:0] i_dr_addr,
	output logic o_dr_valid,
	output logic o_dr_err,
	output logic [feap_pkg::DATA_W-1:0] o_dr_rdata,
	input wire logic i_pg_req,
	input wire logic [feap_pkg::ADDR_W-1:0] i_pg_addr,
	input wire logic [feap_pkg::DATA_W-1:0] i_pg_data,
	output logic o_pg_ready,
	output logic o_pg_done,
	output logic o_pg_err,
	input wire logic i_er_req,
	input wire logic [feap_pkg::ADDR_W-1:0] i_er_addr,
	output logic o_er_ready,
	output logic o_er_done,
	output logic o_er_err,
	output logic o_busy,
	output logic [feap_pkg::WADDR_W-1:0] o_arr_if_addr,
	input wire logic [feap_pkg::DATA_W-1:0] i_arr_if_rdata,
	output logic [feap_pkg::WADDR_W-1:0] o_arr_dr_addr,
	input wire logic [feap_pkg::DATA_W-1:0] i_arr_dr_rdata,
	output logic o_arr_we,
	output logic [feap_pkg::WADDR_W-1:0] o_arr_waddr,
	output logic [feap_pkg::DATA_W-1:0] o_arr_wdata
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ERASE = 2'b10
	} feap_state_t;

	feap_state_t state_r;
	logic [feap_pkg::ERASE_IDX_W-1:0] er_unit_r;
	logic [feap_pkg::WCNT_W-1:0] wcnt_r;
	logic pg_wr_r;
	logic mod_idle;
	logic er_take;
	logic pg_take;

	feap_chk_if if_chk ();
	feap_chk_if dr_chk ();
	feap_chk_if md_chk ();

	// ****************************************************************
	// protection checks
	// ****************************************************************
	assign if_chk.addr = i_if_addr;
	assign if_chk.kind = feap_pkg::KIND_FETCH;
	assign dr_chk.addr = i_dr_addr;
	assign dr_chk.kind = feap_pkg::KIND_DATA;
	// erase has priority over program in the same cycle
	assign md_chk.addr = i_er_req ? i_er_addr : i_pg_addr;
	assign md_chk.kind = feap_pkg::KIND_MODIFY;

	feap_prot_chk u_if_chk (
		.bus(if_chk.chk),
		.i_prot_rd_en(i_prot_rd_en),
		.i_prot_pe_en(i_prot_pe_en)
	);
	feap_prot_chk u_dr_chk (
		.bus(dr_chk.chk),
		.i_prot_rd_en(i_prot_rd_en),
		.i_prot_pe_en(i_prot_pe_en)
	);
	feap_prot_chk u_md_chk (
		.bus(md_chk.chk),
		.i_prot_rd_en(i_prot_rd_en),
		.i_prot_pe_en(i_prot_pe_en)
	);

	// ****************************************************************
	// read paths
	// ****************************************************************
	assign o_arr_if_addr = i_if_addr[feap_pkg::ADDR_W-1:feap_pkg::WORD_LSB];
	assign o_arr_dr_addr = i_dr_addr[feap_pkg::ADDR_W-1:feap_pkg::WORD_LSB];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_if_valid <= 1'b0;
			o_if_rdata <= feap_pkg::DENIED_WORD;
		end else begin
			o_if_valid <= i_if_req;
			if (i_if_req && if_chk.allow) begin
				o_if_rdata <= i_arr_if_rdata;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_dr_valid <= 1'b0;
			o_dr_err <= 1'b0;
			o_dr_rdata <= feap_pkg::DENIED_WORD;
		end else begin
			o_dr_valid <= i_dr_req;
			o_dr_err <= i_dr_req && !dr_chk.allow;
			if (i_dr_req) begin
				// denied data reads never expose the array contents
				o_dr_rdata <= dr_chk.allow ? i_arr_dr_rdata : feap_pkg::DENIED_WORD;
			end
		end
	end

	// ****************************************************************
	// modify requests
	// ****************************************************************
	assign mod_idle = (state_r == ST_IDLE) && !pg_wr_r;
	assign o_er_ready = mod_idle;
	assign o_pg_ready = mod_idle && !i_er_req;
	assign o_busy = !mod_idle;
	assign er_take = mod_idle && i_er_req;
	assign pg_take = mod_idle && !i_er_req && i_pg_req;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
			er_unit_r <= '0;
			wcnt_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (er_take && md_chk.allow) begin
						er_unit_r <= i_er_addr[feap_pkg::ADDR_W-1:feap_pkg::ERASE_LSB];
						wcnt_r <= '0;
						state_r <= ST_ERASE;
					end
				end
				ST_ERASE: begin
					wcnt_r <= wcnt_r + 1'b1;
					if (wcnt_r == feap_pkg::WCNT_LAST) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_er_done <= 1'b0;
			o_er_err <= 1'b0;
		end else begin
			o_er_done <= (state_r == ST_ERASE) && (wcnt_r == feap_pkg::WCNT_LAST);
			o_er_err <= er_take && !md_chk.allow;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pg_wr_r <= 1'b0;
			o_pg_done <= 1'b0;
			o_pg_err <= 1'b0;
		end else begin
			pg_wr_r <= pg_take && md_chk.allow;
			o_pg_done <= pg_wr_r;
			o_pg_err <= pg_take && !md_chk.allow;
		end
	end

	// ****************************************************************
	// array write port
	// ****************************************************************
	// registered so the array sees settled levels; decisions mirror the state update
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_arr_we <= 1'b0;
			o_arr_waddr <= '0;
			o_arr_wdata <= '0;
		end else begin
			// the write strobe drops unless a word is due next cycle
			o_arr_we <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (er_take && md_chk.allow) begin
						// first word of the selected unit
						o_arr_we <= 1'b1;
						o_arr_waddr <= {i_er_addr[feap_pkg::ADDR_W-1:feap_pkg::ERASE_LSB],
							{feap_pkg::WCNT_W{1'b0}}};
						o_arr_wdata <= feap_pkg::ERASED_WORD;
					end else if (pg_take && md_chk.allow) begin
						// a programmed word is written as given
						o_arr_we <= 1'b1;
						o_arr_waddr <= i_pg_addr[feap_pkg::ADDR_W-1:feap_pkg::WORD_LSB];
						o_arr_wdata <= i_pg_data;
					end
				end
				ST_ERASE: begin
					// erase walks only the words of the selected unit
					if (wcnt_r != feap_pkg::WCNT_LAST) begin
						o_arr_we <= 1'b1;
						o_arr_waddr <= {er_unit_r, wcnt_r + 1'b1};
						o_arr_wdata <= feap_pkg::ERASED_WORD;
					end
				end
				default: begin
					o_arr_we <= 1'b0;
				end
			endcase
		end
	end
endmodule : feap_ctrl
`default_nettype wire

// ### feap_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module feap_ctrl_checker (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [63:0] i_prot_rd_en,
	input wire logic [63:0] i_prot_pe_en,
	input wire logic i_if_req,
	input wire logic o_if_valid,
	input wire logic [31:0] o_if_rdata,
	input wire logic [31:0] i_arr_if_rdata,
	input wire logic i_dr_req,
	input wire logic [16:0] i_dr_addr,
	input wire logic o_dr_valid,
	input wire logic o_dr_err,
	input wire logic [31:0] o_dr_rdata,
	input wire logic [31:0] i_arr_dr_rdata,
	input wire logic i_pg_req,
	input wire logic [16:0] i_pg_addr,
	input wire logic [31:0] i_pg_data,
	input wire logic o_pg_ready,
	input wire logic o_pg_done,
	input wire logic o_pg_err,
	input wire logic i_er_req,
	input wire logic [16:0] i_er_addr,
	input wire logic o_er_ready,
	input wire logic o_er_done,
	input wire logic o_er_err,
	input wire logic o_arr_we,
	input wire logic [14:0] o_arr_waddr,
	input wire logic [31:0] o_arr_wdata
);
	wire rdok = i_prot_rd_en[i_dr_addr[16:11]];
	wire erq = i_er_req && o_er_ready;
	wire pge = i_prot_pe_en[i_er_addr[16:11]];
	wire pgq = i_pg_req && o_pg_ready;
	wire pgp = i_prot_pe_en[i_pg_addr[16:11]];
	wire [6:0] eu = i_er_addr[16:10];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_fetch_one_cycle: assert property (i_if_req |=> o_if_valid && o_if_rdata == $past(i_arr_if_rdata))
		else $error("fetch answer wrong");
	a_dread_one_cycle: assert property (i_dr_req |=> o_dr_valid)
		else $error("data read late");
	a_dread_deny: assert property (i_dr_req |=> o_dr_err != $past(rdok))
		else $error("data read deny wrong");
	a_dread_data: assert property (i_dr_req && rdok |=> o_dr_rdata == $past(i_arr_dr_rdata))
		else $error("data read word wrong");
	a_erase_refuse: assert property (erq && !pge |=> o_er_err && !o_arr_we)
		else $error("erase not refused");
	a_prog_refuse: assert property (pgq && !pgp |=> o_pg_err && !o_arr_we)
		else $error("program not refused");
	a_erase_ones: assert property (erq && pge |=> o_arr_waddr == {$past(eu), 8'h00}
		##0 (o_arr_we && o_arr_wdata == 32'hffff_ffff)[*8])
		else $error("erase write wrong");
	a_erase_done: assert property (erq && pge |-> ##257 o_er_done)
		else $error("erase done late");
	a_prog_write: assert property (pgq && pgp |=> o_arr_we && o_arr_wdata == $past(i_pg_data)
		&& o_arr_waddr == $past(i_pg_addr[16:2]) ##1 o_pg_done)
		else $error("program write wrong");
endmodule : feap_ctrl_checker
bind feap_ctrl feap_ctrl_checker feap_ctrl_checker_i (.i_clk(i_clk), .i_rst(i_rst),
	.i_prot_rd_en(i_prot_rd_en), .i_prot_pe_en(i_prot_pe_en), .i_if_req(i_if_req),
	.o_if_valid(o_if_valid), .o_if_rdata(o_if_rdata), .i_arr_if_rdata(i_arr_if_rdata),
	.i_dr_req(i_dr_req), .i_dr_addr(i_dr_addr), .o_dr_valid(o_dr_valid), .o_dr_err(o_dr_err),
	.o_dr_rdata(o_dr_rdata), .i_arr_dr_rdata(i_arr_dr_rdata), .i_pg_req(i_pg_req),
	.i_pg_addr(i_pg_addr), .i_pg_data(i_pg_data), .o_pg_ready(o_pg_ready),
	.o_pg_done(o_pg_done), .o_pg_err(o_pg_err), .i_er_req(i_er_req), .i_er_addr(i_er_addr),
	.o_er_ready(o_er_ready), .o_er_done(o_er_done), .o_er_err(o_er_err), .o_arr_we(o_arr_we),
	.o_arr_waddr(o_arr_waddr), .o_arr_wdata(o_arr_wdata));
`default_nettype wire

// ### feap_arr_model.sv
`timescale 1ns/1ps
`default_nettype none
module feap_arr_model (
	input wire logic i_clk,
	input wire logic [14:0] i_if_addr,
	input wire logic [14:0] i_dr_addr,
	output logic [31:0] o_if_rdata,
	output logic [31:0] o_dr_rdata,
	input wire logic i_we,
	input wire logic [14:0] i_waddr,
	input wire logic [31:0] i_wdata
);
	logic [31:0] mem [32768];
	initial begin
		for (int i = 0; i < 32768; i++) mem[i] = {17'h0, i[14:0]} ^ 32'h5a5a_3c3c;
	end
	assign o_if_rdata = mem[i_if_addr];
	assign o_dr_rdata = mem[i_dr_addr];
	always @(posedge i_clk) begin
		if (i_we) mem[i_waddr] <= i_wdata;
	end
endmodule : feap_arr_model
`default_nettype wire

// ### feap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module feap_tb_top;
	logic i_clk = 0, i_rst = 1, i_if_req = 0, i_dr_req = 0, i_pg_req = 0, i_er_req = 0;
	logic [63:0] i_prot_rd_en = '0, i_prot_pe_en = '0;
	logic [16:0] i_if_addr = '0, i_dr_addr = '0, i_pg_addr = '0, i_er_addr = '0, ra;
	logic [31:0] i_pg_data = '0, pd, o_if_rdata, o_dr_rdata, i_arr_if_rdata, i_arr_dr_rdata;
	logic [31:0] o_arr_wdata, pw, pb;
	logic o_if_valid, o_dr_valid, o_dr_err, o_pg_ready, o_pg_done, o_pg_err;
	logic o_er_ready, o_er_done, o_er_err, o_busy, o_arr_we;
	logic [14:0] o_arr_if_addr, o_arr_dr_addr, o_arr_waddr;
	int n_mismatch = 0, n_tests = 0, seed = 76305;
	feap_ctrl feap_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_prot_rd_en(i_prot_rd_en),
		.i_prot_pe_en(i_prot_pe_en), .i_if_req(i_if_req), .i_if_addr(i_if_addr),
		.o_if_valid(o_if_valid), .o_if_rdata(o_if_rdata), .i_dr_req(i_dr_req),
		.i_dr_addr(i_dr_addr), .o_dr_valid(o_dr_valid), .o_dr_err(o_dr_err),
		.o_dr_rdata(o_dr_rdata), .i_pg_req(i_pg_req), .i_pg_addr(i_pg_addr),
		.i_pg_data(i_pg_data), .o_pg_ready(o_pg_ready), .o_pg_done(o_pg_done),
		.o_pg_err(o_pg_err), .i_er_req(i_er_req), .i_er_addr(i_er_addr),
		.o_er_ready(o_er_ready), .o_er_done(o_er_done), .o_er_err(o_er_err), .o_busy(o_busy),
		.o_arr_if_addr(o_arr_if_addr), .i_arr_if_rdata(i_arr_if_rdata),
		.o_arr_dr_addr(o_arr_dr_addr), .i_arr_dr_rdata(i_arr_dr_rdata), .o_arr_we(o_arr_we),
		.o_arr_waddr(o_arr_waddr), .o_arr_wdata(o_arr_wdata));
	feap_arr_model feap_arr_model_i (.i_clk(i_clk), .i_if_addr(o_arr_if_addr),
		.i_dr_addr(o_arr_dr_addr), .o_if_rdata(i_arr_if_rdata), .o_dr_rdata(i_arr_dr_rdata),
		.i_we(o_arr_we), .i_waddr(o_arr_waddr), .i_wdata(o_arr_wdata));
	always #4 i_clk = ~i_clk;
	function automatic logic [31:0] word(input logic [16:0] a);
		return feap_arr_model_i.mem[a[16:2]];
	endfunction : word
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s exp %h got %h", n, exp, got);
		end
	endtask : chk
	task automatic end_sim;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic reads(input int n);
		logic [31:0] fw, dw;
		logic de;
		repeat (n) begin
			i_if_req = 1;
			i_dr_req = 1;
			i_if_addr = 17'($random(seed));
			i_dr_addr = 17'($random(seed));
			fw = word(i_if_addr);
			dw = word(i_dr_addr);
			de = !i_prot_rd_en[i_dr_addr[16:11]];
			@(posedge i_clk) #1;
			chk("if_valid", o_if_valid, 1);
			chk("if_rdata", o_if_rdata, fw);
			chk("dr_err", {o_dr_valid, o_dr_err}, {1'b1, de});
			chk("dr_rdata", o_dr_rdata, de ? 32'h0 : dw);
		end
		i_if_req = 0;
		i_dr_req = 0;
		$display("reads done");
	endtask : reads
	task automatic op(input logic er, input logic [16:0] a, input logic ok);
		int n;
		chk("ready", {o_er_ready, o_pg_ready, o_busy}, 3'b110);
		pd = $random(seed);
		i_er_req = er;
		i_pg_req = !er;
		i_er_addr = a;
		i_pg_addr = a;
		i_pg_data = pd;
		@(posedge i_clk) #1;
		i_er_req = 0;
		i_pg_req = 0;
		chk("busy", o_busy, ok);
		n = 1;
		while (!(o_er_done | o_er_err | o_pg_done | o_pg_err) && n < 300) begin
			@(posedge i_clk) #1;
			n++;
		end
		chk("latency", n, !ok ? 1 : er ? 257 : 2);
		chk("refused", o_er_err | o_pg_err, !ok);
		chk("idle", o_busy, 0);
		if (ok && !er) chk("pg_word", word(a), pd);
		@(posedge i_clk) #1;
		$display("op done");
	endtask : op
	initial begin
		i_prot_rd_en = {$random(seed), $random(seed)};
		i_prot_pe_en = {$random(seed), $random(seed)};
		i_prot_rd_en[2:0] = 3'h5;
		i_prot_pe_en[2:0] = 3'h4;
		repeat (20) @(posedge i_clk);
		#1 i_rst = 0;
		reads(200);
		for (int u = 0; u < 2; u++) begin
			op(0, 17'(u * 2048 + 8), 0);
			op(1, 17'(u * 2048 + 1024), 0);
		end
		op(0, 17'h1010, 1);
		pw = pd;
		pb = word(17'h1800);
		op(1, 17'h1400, 1);
		chk("neighbour", word(17'h1010), pw);
		chk("above", word(17'h1800), pb);
		for (int w = 0; w < 256; w++) chk("erased", word(17'(17'h1400 + w * 4)), '1);
		repeat (6) begin
			ra = 17'($random(seed));
			op(ra[0], ra, i_prot_pe_en[ra[16:11]]);
		end
		reads(50);
		end_sim();
	end
	initial begin
		#(8 * 20000);
		n_mismatch++;
		end_sim();
	end
endmodule : feap_tb_top
`default_nettype wire
